// ---- rtl/rcc_clock_ram.v ----
// Serial-bus clock, calendar, timer, event counter and 248-byte RAM
`timescale 1ns/10ps
`include "rcc_map.vh"

module rcc_clock_ram (
  input  wire clk,
  input  wire nrst,
  input  wire scl_in,
  input  wire sda_in,
  output reg  sda_out,
  output reg  sda_oe,
  input  wire addr_select_pin,
  input  wire osc_in_pin,
  output reg  osc_out_pin,
  output reg  int_out,
  output reg  int_oe
);

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK  = 3'h2;
  localparam ST_RX   = 3'h3;
  localparam ST_TX   = 3'h4;
  localparam ST_RACK = 3'h5;

  reg  [2:0]  scl_s;
  reg  [2:0]  sda_s;
  reg  [2:0]  osc_s;
  reg  [1:0]  a0_s;
  reg  [2:0]  st_r;
  reg  [3:0]  bit_r;
  reg  [7:0]  sh_r;
  reg         rw_r;
  reg         first_r;
  reg  [7:0]  ptr_r;
  reg         wr_stb_r;
  reg  [7:0]  wr_adr_r;
  reg  [7:0]  wr_dat_r;
  reg         cap_stb_r;
  reg  [7:0]  rdata;
  reg  [16:0] acc_r;
  reg         tick_r;
  reg         evt_r;
  reg         chk_r;
  reg  [7:0]  cs_r, hs_r, sec_r, min_r, hr_r, yd_r, wm_r, tmr_r;
  reg  [7:0]  cs_nxt, hs_nxt, sec_nxt, min_nxt, hr_nxt, yd_nxt, wm_nxt, tmr_nxt;
  reg  [7:0]  cap_hs, cap_sec, cap_min, cap_hr, cap_yd, cap_wm, cap_tmr;
  reg  [7:0]  ram_r [8:255];
  reg         c1, c2, c3, c4, tinc, tovf, clk_hit;
  reg  [5:0]  dmax;
  reg  [7:0]  hr_inc, dt_inc, mo_inc;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == 4'h9) begin
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
        bcd_inc = v + 8'h01;
      end
    end
  endfunction

  function [7:0] bcd_step;
    input [7:0] v;
    input [7:0] top;
    begin
      bcd_step = (v == top) ? 8'h00 : bcd_inc(v);
    end
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      osc_s <= 3'h0;
      a0_s  <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      osc_s <= {osc_s[1:0], osc_in_pin};
      a0_s  <= {a0_s[0], addr_select_pin};
    end
  end

  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  wire bus_stop = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
  wire osc_rise = osc_s[1] & ~osc_s[2];
  wire osc_fall = ~osc_s[1] & osc_s[2];
  wire [1:0] mode = cs_r[`RCC_CS_MODE];
  wire [7:0] ac = ram_r[`RCC_ADR_ACTRL];
  wire [7:0] al_wm = ram_r[`RCC_ADR_AL_WMON];
  wire [7:0] al_dt = ram_r[`RCC_ADR_AL_DATE];
  wire [16:0] acc_sum = acc_r + `RCC_TICK_HZ;
  wire dev_hit = (sh_r[7:1] == {`RCC_DEV_ADDR, a0_s[1]});
  wire load_tx = scl_fall & (((st_r == ST_ACK) & rw_r) | (st_r == ST_RACK));

  // ---------------------------------------------------------------
  // Serial bus slave
  // ---------------------------------------------------------------
  always @* begin
    case (ptr_r)
      `RCC_ADR_CTRL:  rdata = cs_r;
      `RCC_ADR_HSEC:  rdata = cap_hs;
      `RCC_ADR_SEC:   rdata = cap_sec;
      `RCC_ADR_MIN:   rdata = cap_min;
      `RCC_ADR_HOUR:  rdata = cap_hr;
      `RCC_ADR_YDATE: rdata = cs_r[`RCC_CS_MASK] ? {2'h0, cap_yd[`RCC_DATE]} : cap_yd;
      `RCC_ADR_WMON:  rdata = cs_r[`RCC_CS_MASK] ? {3'h0, cap_wm[`RCC_MONTH]} : cap_wm;
      `RCC_ADR_TIMER: rdata = cap_tmr;
      default:        rdata = ram_r[ptr_r];
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      st_r      <= ST_IDLE;
      bit_r     <= 4'h0;
      sh_r      <= 8'h00;
      rw_r      <= 1'b0;
      first_r   <= 1'b0;
      ptr_r     <= 8'h00;
      wr_stb_r  <= 1'b0;
      wr_adr_r  <= 8'h00;
      wr_dat_r  <= 8'h00;
      cap_stb_r <= 1'b0;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
    end else begin
      wr_stb_r  <= 1'b0;
      cap_stb_r <= 1'b0;
      if (bus_start) begin
        st_r    <= ST_ADDR;
        bit_r   <= 4'h0;
        first_r <= 1'b1;
        sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        st_r   <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (load_tx) begin
        sda_oe <= ~rdata[7];
        sh_r   <= {rdata[6:0], 1'b0};
        bit_r  <= 4'h1;
        ptr_r  <= ptr_r + 8'h01;
        st_r   <= ST_TX;
      end else begin
        case (st_r)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              sh_r  <= {sh_r[6:0], sda_s[1]};
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              if (st_r == ST_ADDR) begin
                if (dev_hit) begin
                  rw_r      <= sh_r[0];
                  cap_stb_r <= sh_r[0];
                  sda_oe    <= 1'b1;
                  st_r      <= ST_ACK;
                end else begin
                  st_r <= ST_IDLE;
                end
              end else begin
                sda_oe  <= 1'b1;
                st_r    <= ST_ACK;
                first_r <= 1'b0;
                if (first_r) begin
                  ptr_r <= sh_r;
                end else begin
                  wr_stb_r <= 1'b1;
                  wr_adr_r <= ptr_r;
                  wr_dat_r <= sh_r;
                  ptr_r    <= ptr_r + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bit_r  <= 4'h0;
              st_r   <= ST_RX;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_r == 4'h8) begin
                sda_oe <= 1'b0;
                st_r   <= ST_RACK;
              end else begin
                sda_oe <= ~sh_r[7];
                sh_r   <= {sh_r[6:0], 1'b0};
                bit_r  <= bit_r + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise && sda_s[1]) begin
              st_r <= ST_IDLE;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // RAM and alarm registers
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (wr_stb_r && wr_adr_r >= `RCC_ADR_ACTRL) begin
      ram_r[wr_adr_r] <= wr_dat_r;
    end
  end

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      acc_r       <= 17'h00000;
      tick_r      <= 1'b0;
      evt_r       <= 1'b0;
      chk_r       <= 1'b0;
      osc_out_pin <= 1'b0;
    end else begin
      tick_r      <= 1'b0;
      evt_r       <= 1'b0;
      chk_r       <= tick_r | evt_r;
      osc_out_pin <= (mode == `RCC_MODE_XTAL) ? ~osc_s[1] : 1'b0;
      if (!cs_r[`RCC_CS_STOP]) begin
        case (mode)
          `RCC_MODE_XTAL: begin
            if (osc_rise) begin
              if (acc_sum >= `RCC_XTAL_HZ) begin
                acc_r  <= acc_sum - `RCC_XTAL_HZ;
                tick_r <= 1'b1;
              end else begin
                acc_r <= acc_sum;
              end
            end
          end
          `RCC_MODE_50HZ:  tick_r <= osc_rise | osc_fall;
          `RCC_MODE_EVENT: evt_r <= osc_rise;
          default:         tick_r <= 1'b0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Counters and flags
  // ---------------------------------------------------------------
  always @* begin
    case (wm_r[`RCC_MONTH])
      5'h02:                      dmax = (yd_r[`RCC_YEAR] == 2'h0) ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11: dmax = 6'h30;
      default:                    dmax = 6'h31;
    endcase
  end

  wire al_base = (hs_r == ram_r[`RCC_ADR_AL_HSEC]) & (sec_r == ram_r[`RCC_ADR_AL_SEC]) &
                 (min_r == ram_r[`RCC_ADR_AL_MIN]);
  wire al_hour = al_base & (hr_r == ram_r[`RCC_ADR_AL_HOUR]);
  wire tmr_hit = ac[`RCC_AC_TALM] & (tmr_r == ram_r[`RCC_ADR_AL_TIMER]);
  wire evt_hit = (mode == `RCC_MODE_EVENT) & (ac[`RCC_AC_ALM] == `RCC_AL_DAILY) & al_base;

  always @* begin
    case (ac[`RCC_AC_ALM])
      `RCC_AL_DAILY:   clk_hit = al_hour;
      `RCC_AL_WEEKDAY: clk_hit = al_hour & al_wm[wm_r[`RCC_WDAY]];
      `RCC_AL_DATED:   clk_hit = al_hour & (yd_r[`RCC_DATE] == al_dt[`RCC_DATE]) &
                                 (wm_r[`RCC_MONTH] == al_wm[`RCC_MONTH]);
      default:         clk_hit = 1'b0;
    endcase
  end

  wire alarm_hit = ((mode == `RCC_MODE_EVENT) ? evt_hit : clk_hit) | tmr_hit;

  always @* begin
    cs_nxt  = cs_r;
    hs_nxt  = hs_r;
    sec_nxt = sec_r;
    min_nxt = min_r;
    hr_nxt  = hr_r;
    yd_nxt  = yd_r;
    wm_nxt  = wm_r;
    tmr_nxt = tmr_r;
    c1 = 1'b0;
    c2 = 1'b0;
    c3 = 1'b0;
    c4 = 1'b0;
    tinc = 1'b0;
    tovf = 1'b0;
    hr_inc = bcd_inc({2'h0, hr_r[`RCC_HR_DIGITS]});
    dt_inc = bcd_inc({2'h0, yd_r[`RCC_DATE]});
    mo_inc = bcd_inc({3'h0, wm_r[`RCC_MONTH]});
    if (tick_r || evt_r) begin
      hs_nxt = bcd_step(hs_r, `RCC_BCD_99);
      c1 = (hs_r == `RCC_BCD_99);
      if (c1) begin
        sec_nxt = bcd_step(sec_r, evt_r ? `RCC_BCD_99 : `RCC_BCD_59);
        c2 = (sec_r == (evt_r ? `RCC_BCD_99 : `RCC_BCD_59));
      end
      if (c2) begin
        min_nxt = bcd_step(min_r, evt_r ? `RCC_BCD_99 : `RCC_BCD_59);
        c3 = (min_r == (evt_r ? `RCC_BCD_99 : `RCC_BCD_59));
      end
      if (c3 && tick_r) begin
        if (!hr_r[`RCC_HR_12H]) begin
          hr_nxt[`RCC_HR_DIGITS] = (hr_r[`RCC_HR_DIGITS] == 6'h23) ? 6'h00 : hr_inc[5:0];
          c4 = (hr_r[`RCC_HR_DIGITS] == 6'h23);
        end else if (hr_r[`RCC_HR_DIGITS] == 6'h11) begin
          hr_nxt[`RCC_HR_DIGITS] = 6'h12;
          hr_nxt[`RCC_HR_PM] = ~hr_r[`RCC_HR_PM];
          c4 = hr_r[`RCC_HR_PM];
        end else if (hr_r[`RCC_HR_DIGITS] == 6'h12) begin
          hr_nxt[`RCC_HR_DIGITS] = 6'h01;
        end else begin
          hr_nxt[`RCC_HR_DIGITS] = hr_inc[5:0];
        end
      end
      if (c4) begin
        wm_nxt[`RCC_WDAY] = (wm_r[`RCC_WDAY] == 3'h6) ? 3'h0 : wm_r[`RCC_WDAY] + 3'h1;
        if (yd_r[`RCC_DATE] == dmax) begin
          yd_nxt[`RCC_DATE] = 6'h01;
          if (wm_r[`RCC_MONTH] == 5'h12) begin
            wm_nxt[`RCC_MONTH] = 5'h01;
            yd_nxt[`RCC_YEAR] = yd_r[`RCC_YEAR] + 2'h1;
          end else begin
            wm_nxt[`RCC_MONTH] = mo_inc[4:0];
          end
        end else begin
          yd_nxt[`RCC_DATE] = dt_inc[5:0];
        end
      end
      if (!cs_r[`RCC_CS_AEN] && tick_r) begin
        tinc = c4;
      end else begin
        case (ac[`RCC_AC_RES])
          3'h0:    tinc = 1'b1;
          3'h1:    tinc = c1;
          3'h2:    tinc = c2;
          3'h3:    tinc = c3;
          3'h4:    tinc = c4;
          default: tinc = 1'b0;
        endcase
      end
      if (tinc) begin
        tmr_nxt = bcd_step(tmr_r, `RCC_BCD_99);
        tovf = (tmr_r == `RCC_BCD_99);
      end
    end
    if (wr_stb_r) begin
      case (wr_adr_r)
        `RCC_ADR_CTRL:  cs_nxt = wr_dat_r;
        `RCC_ADR_HSEC:  hs_nxt = wr_dat_r;
        `RCC_ADR_SEC:   sec_nxt = wr_dat_r;
        `RCC_ADR_MIN:   min_nxt = wr_dat_r;
        `RCC_ADR_HOUR:  hr_nxt = wr_dat_r;
        `RCC_ADR_YDATE: yd_nxt = wr_dat_r;
        `RCC_ADR_WMON:  wm_nxt = wr_dat_r;
        `RCC_ADR_TIMER: tmr_nxt = wr_dat_r;
        default:        cs_nxt = cs_nxt;
      endcase
    end
    cs_nxt[`RCC_CS_TFLAG] = cs_nxt[`RCC_CS_TFLAG] | tovf;
    cs_nxt[`RCC_CS_AFLAG] = cs_nxt[`RCC_CS_AFLAG] | (chk_r & cs_r[`RCC_CS_AEN] & alarm_hit);
  end

  always @(posedge clk) begin
    if (!nrst) begin
      cs_r    <= `RCC_RST_CTRL;
      hs_r    <= `RCC_RST_TIME;
      sec_r   <= `RCC_RST_TIME;
      min_r   <= `RCC_RST_TIME;
      hr_r    <= `RCC_RST_TIME;
      yd_r    <= `RCC_RST_YDATE;
      wm_r    <= `RCC_RST_WMON;
      tmr_r   <= `RCC_RST_TIME;
      cap_hs  <= 8'h00;
      cap_sec <= 8'h00;
      cap_min <= 8'h00;
      cap_hr  <= 8'h00;
      cap_yd  <= 8'h00;
      cap_wm  <= 8'h00;
      cap_tmr <= 8'h00;
      int_oe  <= 1'b0;
      int_out <= 1'b0;
    end else begin
      cs_r  <= cs_nxt;
      hs_r  <= hs_nxt;
      sec_r <= sec_nxt;
      min_r <= min_nxt;
      hr_r  <= hr_nxt;
      yd_r  <= yd_nxt;
      wm_r  <= wm_nxt;
      tmr_r <= tmr_nxt;
      if (cap_stb_r) begin
        cap_hs  <= hs_r;
        cap_sec <= sec_r;
        cap_min <= min_r;
        cap_hr  <= hr_r;
        cap_yd  <= yd_r;
        cap_wm  <= wm_r;
        cap_tmr <= tmr_r;
      end
      if (cs_r[`RCC_CS_AEN]) begin
        int_oe <= (cs_r[`RCC_CS_AFLAG] & ac[`RCC_AC_AINT]) |
                  (cs_r[`RCC_CS_TFLAG] & ac[`RCC_AC_TINT]);
      end else begin
        int_oe <= ~mode[1] & (hs_r >= `RCC_HALF_SEC);
      end
    end
  end

endmodule // rcc_clock_ram

// ---- rtl/rcc_map.vh ----
// Address map, field positions, reset values and constants of the clock and RAM block
`ifndef RCC_MAP_VH
`define RCC_MAP_VH
`define RCC_ADR_CTRL     8'h00
`define RCC_ADR_HSEC     8'h01
`define RCC_ADR_SEC      8'h02
`define RCC_ADR_MIN      8'h03
`define RCC_ADR_HOUR     8'h04
`define RCC_ADR_YDATE    8'h05
`define RCC_ADR_WMON     8'h06
`define RCC_ADR_TIMER    8'h07
`define RCC_ADR_ACTRL    8'h08
`define RCC_ADR_AL_HSEC  8'h09
`define RCC_ADR_AL_SEC   8'h0a
`define RCC_ADR_AL_MIN   8'h0b
`define RCC_ADR_AL_HOUR  8'h0c
`define RCC_ADR_AL_DATE  8'h0d
`define RCC_ADR_AL_WMON  8'h0e
`define RCC_ADR_AL_TIMER 8'h0f
`define RCC_CS_TFLAG     0
`define RCC_CS_AFLAG     1
`define RCC_CS_AEN       2
`define RCC_CS_MASK      3
`define RCC_CS_MODE      5:4
`define RCC_CS_STOP      7
`define RCC_MODE_XTAL    2'h0
`define RCC_MODE_50HZ    2'h1
`define RCC_MODE_EVENT   2'h2
`define RCC_AC_RES       2:0
`define RCC_AC_TINT      3
`define RCC_AC_ALM       5:4
`define RCC_AC_TALM      6
`define RCC_AC_AINT      7
`define RCC_AL_DAILY     2'h1
`define RCC_AL_WEEKDAY   2'h2
`define RCC_AL_DATED     2'h3
`define RCC_HR_12H       7
`define RCC_HR_PM        6
`define RCC_HR_DIGITS    5:0
`define RCC_YEAR         7:6
`define RCC_DATE         5:0
`define RCC_WDAY         7:5
`define RCC_MONTH        4:0
`define RCC_RST_CTRL     8'h00
`define RCC_RST_TIME     8'h00
`define RCC_RST_YDATE    8'h01
`define RCC_RST_WMON     8'h01
`define RCC_DEV_ADDR     6'h28
`define RCC_XTAL_HZ      17'h08000
`define RCC_TICK_HZ      17'h00064
`define RCC_HALF_SEC     8'h50
`define RCC_BCD_99       8'h99
`define RCC_BCD_59       8'h59
`endif

// ---- tb/rcc_clock_ram_assertions.sv ----
// Concurrent checks on the pins of the clock and RAM block
`timescale 1ns/10ps
module rcc_clock_ram_checker (
  input wire clk,
  input wire nrst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire addr_select_pin,
  input wire osc_in_pin,
  input wire osc_out_pin,
  input wire int_out,
  input wire int_oe
);
  // ----------------------------------
  // Pin checks
  // ----------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_sda_data_low;
    sda_out == 1'b0;
  endproperty
  a_sda_data_low: assert property (p_sda_data_low) else $error("sda data not low");

  property p_int_data_low;
    int_out == 1'b0;
  endproperty
  a_int_data_low: assert property (p_int_data_low) else $error("int data not low");

  property p_reset_quiet;
    disable iff (1'b0) !nrst |=> !sda_oe && !int_oe && !osc_out_pin;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("pins driven in reset");

  property p_int_starts_high;
    $rose(nrst) |-> (!int_oe) [*8];
  endproperty
  a_int_starts_high: assert property (p_int_starts_high) else $error("int low at start");

  property p_osc_echo_off;
    osc_in_pin [*3] |=> !osc_out_pin;
  endproperty
  a_osc_echo_off: assert property (p_osc_echo_off) else $error("osc echo not inverted");

  property p_drive_in_low;
    $rose(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  a_drive_in_low: assert property (p_drive_in_low) else $error("sda pulled in clock high");

  property p_release_in_low;
    $fell(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_release_in_low: assert property (p_release_in_low) else $error("sda freed in clock high");

  property p_stable_in_high;
    scl_in [*4] |-> $stable(sda_oe);
  endproperty
  a_stable_in_high: assert property (p_stable_in_high) else $error("sda moved in clock high");

  property p_drive_min;
    $rose(sda_oe) |-> sda_oe [*4];
  endproperty
  a_drive_min: assert property (p_drive_min) else $error("sda drive too short");
endmodule // rcc_clock_ram_checker

bind rcc_clock_ram rcc_clock_ram_checker chk_u (
  .clk             (clk),
  .nrst            (nrst),
  .scl_in          (scl_in),
  .sda_in          (sda_in),
  .sda_out         (sda_out),
  .sda_oe          (sda_oe),
  .addr_select_pin (addr_select_pin),
  .osc_in_pin      (osc_in_pin),
  .osc_out_pin     (osc_out_pin),
  .int_out         (int_out),
  .int_oe          (int_oe)
);

// ---- tb/rcc_i2c_master.sv ----
// Serial bus master model for the clock and RAM block
`timescale 1ns/10ps
module rcc_i2c_master (
  input  wire clk,
  input  wire dev_pull,
  output reg  scl,
  output wire sda
);
  // ----------------------------------
  // Open-drain bus and bit timing
  // ----------------------------------
  reg pull_r = 1'b0;
  initial scl = 1'b1;
  assign sda = ~(pull_r | dev_pull);
  task hl(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task bit_clk(output logic v);
    hl(6);
    scl = 1'b1;
    hl(4);
    v = sda;
    hl(4);
    scl = 1'b0;
    hl(2);
  endtask
  task start;
    pull_r = 1'b0;
    hl(6);
    scl = 1'b1;
    hl(8);
    pull_r = 1'b1;
    hl(8);
    scl = 1'b0;
    hl(2);
  endtask
  task stop;
    pull_r = 1'b1;
    hl(6);
    scl = 1'b1;
    hl(8);
    pull_r = 1'b0;
    hl(8);
  endtask
  task send(input logic [7:0] b, output logic ack);
    integer i;
    logic   v;
    for (i = 7; i >= 0; i--) begin
      pull_r = ~b[i];
      bit_clk(v);
    end
    pull_r = 1'b0;
    bit_clk(v);
    ack = ~v;
  endtask
  task recv(input logic nack, output logic [7:0] b);
    integer i;
    logic   v;
    pull_r = 1'b0;
    for (i = 7; i >= 0; i--)
      bit_clk(b[i]);
    pull_r = ~nack;
    bit_clk(v);
  endtask
endmodule // rcc_i2c_master

// ---- tb/test_rcc_clock_ram.sv ----
// Self-checking bench for the clock and RAM block
`timescale 1ns/10ps
module test_rcc_clock_ram;
  // ----------------------------------
  // Signals and instances
  // ----------------------------------
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg         sel = 1'b0;
  reg         osc = 1'b0;
  wire        scl;
  wire        sda;
  wire        sda_out;
  wire        sda_oe;
  wire        osc_out;
  wire        int_out;
  wire        int_oe;
  integer     n_fail = 0;
  integer     total_checks = 0;
  integer     i;
  logic       ack;
  logic [7:0] rb [0:7];
  logic [7:0] rst_map [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};

  always #20 clk = ~clk;

  rcc_clock_ram dut_u (
    .clk             (clk),
    .nrst            (nrst),
    .scl_in          (scl),
    .sda_in          (sda),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .addr_select_pin (sel),
    .osc_in_pin      (osc),
    .osc_out_pin     (osc_out),
    .int_out         (int_out),
    .int_oe          (int_oe)
  );
  rcc_i2c_master mst_u (
    .clk      (clk),
    .dev_pull (sda_oe),
    .scl      (scl),
    .sda      (sda)
  );

  // ----------------------------------
  // Bus and oscillator tasks and checks
  // ----------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task set_ptr(input logic [7:0] p);
    mst_u.start();
    mst_u.send(8'ha0 | {6'h00, sel, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01);
    mst_u.send(p, ack);
    chk({7'h00, ack}, 8'h01);
  endtask
  task wr(input logic [7:0] p, input logic [7:0] d[$]);
    integer j;
    set_ptr(p);
    for (j = 0; j < d.size(); j++) begin
      mst_u.send(d[j], ack);
      chk({7'h00, ack}, 8'h01);
    end
    mst_u.stop();
  endtask
  task rd(input logic [7:0] p, input integer n);
    integer j;
    set_ptr(p);
    mst_u.start();
    mst_u.send(8'ha1 | {6'h00, sel, 1'b0}, ack);
    chk({7'h00, ack}, 8'h01);
    for (j = 0; j < n; j++)
      mst_u.recv(j == n - 1, rb[j]);
    mst_u.stop();
  endtask
  task pulse(input integer n);
    repeat (n) begin
      osc = 1'b1;
      repeat (3) @(negedge clk);
      osc = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask

  // ----------------------------------
  // Test sequence
  // ----------------------------------
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    rd(8'h00, 8);
    for (i = 0; i < 8; i++)
      chk(rb[i], rst_map[i]);
    sel = 1'b1;
    mst_u.start();
    mst_u.send(8'ha0, ack);
    chk({7'h00, ack}, 8'h00);
    mst_u.stop();
    wr(8'h10, '{8'h5a, 8'ha5, 8'h0f});
    rd(8'h10, 3);
    chk(rb[0], 8'h5a);
    chk(rb[1], 8'ha5);
    chk(rb[2], 8'h0f);
    wr(8'hff, '{8'h96});
    rd(8'hff, 2);
    chk(rb[0], 8'h96);
    chk(rb[1], 8'h00);
    sel = 1'b0;
    wr(8'h08, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88});
    rd(8'h08, 8);
    for (i = 0; i < 8; i++)
      chk(rb[i], 8'(8'h11 * (i + 1)));
    wr(8'h02, '{8'h59});
    rd(8'h01, 7);
    for (i = 0; i < 7; i++)
      chk(rb[i], (i == 1) ? 8'h59 : rst_map[i + 1]);
    wr(8'h05, '{8'hc5, 8'hc3});
    wr(8'h00, '{8'h08});
    rd(8'h05, 2);
    chk(rb[0], 8'h05);
    chk(rb[1], 8'h03);
    rd(8'h00, 1);
    chk(rb[0], 8'h08);
    wr(8'h00, '{8'h00});
    rd(8'h05, 2);
    chk(rb[0], 8'hc5);
    chk(rb[1], 8'hc3);
    wr(8'h01, '{8'h50});
    chk({7'h00, int_oe}, 8'h01);
    wr(8'h01, '{8'h49});
    chk({7'h00, int_oe}, 8'h00);
    wr(8'h07, '{8'h99, 8'h08});
    wr(8'h00, '{8'h04});
    pulse(327);
    rd(8'h01, 1);
    chk(rb[0], 8'h49);
    pulse(1);
    rd(8'h00, 8);
    chk(rb[0], 8'h05);
    chk(rb[1], 8'h50);
    chk(rb[7], 8'h00);
    chk({7'h00, int_oe}, 8'h01);
    wr(8'h00, '{8'h04});
    chk({7'h00, int_oe}, 8'h00);
    wr(8'h00, '{8'h10});
    wr(8'h01, '{8'h00});
    pulse(3);
    rd(8'h01, 1);
    chk(rb[0], 8'h06);
    wr(8'h00, '{8'h20});
    wr(8'h01, '{8'h99, 8'h99, 8'h09});
    pulse(2);
    rd(8'h01, 3);
    chk(rb[0], 8'h01);
    chk(rb[1], 8'h00);
    chk(rb[2], 8'h10);
    wr(8'h00, '{8'h10});
    wr(8'h01, '{8'h98, 8'h59, 8'h59, 8'h91});
    wr(8'h08, '{8'h90, 8'h00, 8'h00, 8'h00, 8'hd2});
    wr(8'h00, '{8'h14});
    pulse(1);
    rd(8'h00, 5);
    chk(rb[0], 8'h16);
    chk(rb[1], 8'h00);
    chk(rb[4], 8'hd2);
    chk({7'h00, int_oe}, 8'h01);
    wr(8'h00, '{8'h14});
    chk({7'h00, int_oe}, 8'h00);
    report_and_stop();
  end

  initial begin
    #2000000;
    n_fail = n_fail + 1;
    report_and_stop();
  end
endmodule // test_rcc_clock_ram
